// file: hfp_pkg.sv
// package: offsets, fields, reset values and sizes for the host fifo partition block
package hfp_pkg;
	// register offsets (byte addresses on the device port)
	localparam logic [7:0] HFP_OFS_RX_DATA = 8'h00;
	localparam logic [7:0] HFP_OFS_RX_STAT = 8'h40;
	localparam logic [7:0] HFP_OFS_HARDWARE_CONFIGURATION = 8'h74;
	localparam logic [7:0] HFP_OFS_RX_PATH = 8'h78;
	localparam logic [7:0] HFP_OFS_RX_INF = 8'h7c;
	localparam logic [7:0] HFP_OFS_TX_INF = 8'h80;
	localparam logic [7:0] HFP_OFS_DROP = 8'ha0;
	// hardware_configuration fields
	localparam int HFP_SOFT_RESET_REQUEST_BIT = 0;
	localparam int HFP_SOFT_RESET_TIMEOUT_FLAG_BIT = 1;
	localparam int HFP_TXSZ_LSB = 16;
	localparam int HFP_MBO_BIT = 20;
	localparam int HFP_FSELEND_BIT = 28;
	localparam int HFP_FPORTEND_BIT = 29;
	localparam logic [3:0] HFP_TXSZ_RESET = 4'h5;
	// receive_path_control field
	localparam int HFP_FFWD_BIT = 31;
	// memory partition
	localparam int HFP_TOTAL_BYTES = 16384;
	localparam int HFP_KB = 1024;
	localparam int HFP_TX_STAT_BYTES = 512;
	localparam int HFP_RX_STAT_DIV = 16;
	localparam int HFP_RX_FULL_MARGIN_DW = 4;
	localparam int HFP_MIL_TX_BYTES = 2048;
	localparam int HFP_MIL_RX_BYTES = 128;
	// soft reset timing
	localparam int HFP_CLK_MHZ = 40;
	localparam int HFP_SOFT_RESET_TIMEOUT_FLAG_US = 10;
	localparam int HFP_SOFT_RESET_TIMEOUT_FLAG_CYC = HFP_SOFT_RESET_TIMEOUT_FLAG_US * HFP_CLK_MHZ;
	localparam int HFP_SOFT_RESET_REQUEST_DONE_CYC = 4;
endpackage

// file: hfp_if.sv
// interface: host bus between controller end and device end
interface hfp_if;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	logic [31:0] rdata;
	modport dev (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

// file: hfp_rx_mil.sv
// module: small internal receive buffer between mac and receive data fifo
module hfp_rx_mil #(
	parameter int DW = 32,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clr,
	// fill side
	input wire logic [DW-1:0] in_data,
	input wire logic in_last,
	input wire logic in_valid,
	output logic in_ready,
	// drain side
	output logic [DW:0] out_word,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [DW:0] mem [DEPTH];
	logic [AW:0] wp_r;
	logic [AW:0] rp_r;
	logic full;
	logic empty;
	assign empty = (wp_r == rp_r);
	assign full = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_word = mem[rp_r[AW-1:0]];
	always_ff @(posedge core_clk) begin
		if (in_valid && !full) begin
			mem[wp_r[AW-1:0]] <= {in_last, in_data};
		end
	end
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
		end else if (clr) begin
			wp_r <= '0;
			rp_r <= '0;
		end else begin
			if (in_valid && !full) begin
				wp_r <= wp_r + 1'b1;
			end
			if (out_ready && !empty) begin
				rp_r <= rp_r + 1'b1;
			end
		end
	end
endmodule

// file: hfp_device.sv
// module: device end, fifo partition, receive path, soft reset and skip control
//
// Added by the designer: the strobed register port.

module hfp_device import hfp_pkg::*; #(
	parameter int RX_WORDS = 4096,
	parameter int SOFT_RESET_TIMEOUT_FLAG_CYC = HFP_SOFT_RESET_TIMEOUT_FLAG_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// host bus
	hfp_if.dev bus,
	// mac receive stream
	input wire logic [31:0] mac_rx_data,
	input wire logic mac_rx_last,
	input wire logic mac_rx_valid,
	input wire logic mac_rx_err,
	// mac transmit side
	input wire logic mac_tx_err,
	input wire logic mac_tx_take,
	output logic mac_tx_avail,
	// phy clock status
	input wire logic phy_clks_running,
	// straps and status out
	input wire logic amdix_strap,
	output logic tx_error_flag_r,
	output logic rx_error_flag_r,
	output logic rx_data_full_r
);
	typedef enum logic [1:0] {HFP_SR_IDLE, HFP_SR_RUN, HFP_SR_DONE} hfp_sr_e;
	localparam int PW = $clog2(RX_WORDS) + 1;

	// ==========================================================
	// configuration registers
	hfp_sr_e sr_state_r;
	logic [15:0] sr_cnt_r;
	logic soft_reset_request_r;
	logic soft_reset_timeout_flag_r;
	logic [3:0] transmit_alloc_size_r;
	logic mbo_r;
	logic [1:0] kept_across_soft_reset_r;
	logic amdix_r;
	logic read_seen_r;
	logic sr_clear;
	logic wr_ok;
	assign wr_ok = bus.wr && read_seen_r;
	assign sr_clear = (sr_state_r == HFP_SR_DONE);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			read_seen_r <= 1'b0;
		end else if (bus.rd) begin
			read_seen_r <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		amdix_r <= amdix_strap;
	end

	// soft reset sequencer; timeout if phy clocks are stopped
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sr_state_r <= HFP_SR_IDLE;
			sr_cnt_r <= '0;
			soft_reset_request_r <= 1'b0;
			soft_reset_timeout_flag_r <= 1'b0;
		end else begin
			case (sr_state_r)
				HFP_SR_IDLE: begin
					if (wr_ok && bus.addr == HFP_OFS_HARDWARE_CONFIGURATION && bus.wdata[HFP_SOFT_RESET_REQUEST_BIT]) begin
						soft_reset_request_r <= 1'b1;
						soft_reset_timeout_flag_r <= 1'b0;
						sr_cnt_r <= '0;
						sr_state_r <= HFP_SR_RUN;
					end
				end
				HFP_SR_RUN: begin
					sr_cnt_r <= sr_cnt_r + 16'h0001;
					if (phy_clks_running && sr_cnt_r >= 16'(HFP_SOFT_RESET_REQUEST_DONE_CYC)) begin
						sr_state_r <= HFP_SR_DONE;
					end else if (sr_cnt_r >= 16'(SOFT_RESET_TIMEOUT_FLAG_CYC)) begin
						soft_reset_timeout_flag_r <= 1'b1;
						soft_reset_request_r <= 1'b0;
						sr_state_r <= HFP_SR_IDLE;
					end
				end
				HFP_SR_DONE: begin
					soft_reset_request_r <= 1'b0;
					sr_state_r <= HFP_SR_IDLE;
				end
				default: sr_state_r <= HFP_SR_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			transmit_alloc_size_r <= HFP_TXSZ_RESET;
			mbo_r <= 1'b0;
		end else if (sr_clear) begin
			transmit_alloc_size_r <= HFP_TXSZ_RESET;
			mbo_r <= 1'b0;
		end else if (wr_ok && bus.addr == HFP_OFS_HARDWARE_CONFIGURATION) begin
			transmit_alloc_size_r <= bus.wdata[HFP_TXSZ_LSB +: 4];
			mbo_r <= bus.wdata[HFP_MBO_BIT];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			kept_across_soft_reset_r <= 2'b00;
		end else if (wr_ok && bus.addr == HFP_OFS_HARDWARE_CONFIGURATION) begin
			kept_across_soft_reset_r <= {bus.wdata[HFP_FPORTEND_BIT], bus.wdata[HFP_FSELEND_BIT]};
		end
	end

	// error flags: event wins over the soft reset clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_error_flag_r <= 1'b0;
			rx_error_flag_r <= 1'b0;
		end else begin
			tx_error_flag_r <= mac_tx_err | (tx_error_flag_r & !sr_clear);
			rx_error_flag_r <= mac_rx_err | (rx_error_flag_r & !sr_clear);
		end
	end

	// ==========================================================
	// partition arithmetic
	logic [15:0] tx_total;
	logic [15:0] tx_data_bytes;
	logic [15:0] rx_total;
	logic [15:0] rx_stat_bytes;
	logic [15:0] rx_data_bytes;
	logic [PW-1:0] rx_cap_dw;
	assign tx_total = 16'(transmit_alloc_size_r) * 16'(HFP_KB);
	assign tx_data_bytes = tx_total - 16'(HFP_TX_STAT_BYTES);
	assign rx_total = 16'(HFP_TOTAL_BYTES) - tx_total;
	assign rx_stat_bytes = rx_total / 16'(HFP_RX_STAT_DIV);
	assign rx_data_bytes = rx_total - rx_stat_bytes;
	assign rx_cap_dw = PW'(rx_data_bytes >> 2) - PW'(HFP_RX_FULL_MARGIN_DW);

	// ==========================================================
	// receive path through the internal buffer
	logic [32:0] mil_word;
	logic mil_valid;
	logic mil_in_ready;
	logic rx_take;
	logic dropping_r;
	logic in_frame_r;
	logic [15:0] drop_cnt_r;
	logic [31:0] rx_mem [RX_WORDS];
	logic rx_last_mem [RX_WORDS];
	logic [PW-1:0] rx_wp_r;
	logic [PW-1:0] rx_rp_r;
	logic [PW-1:0] rx_used;
	logic ffwd_r;
	logic rx_pop;
	assign rx_used = rx_wp_r - rx_rp_r;
	assign rx_take = mil_valid && !rx_data_full_r;

	hfp_rx_mil #(.DW(32), .DEPTH(HFP_MIL_RX_BYTES / 4)) u_rx_mil (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clr(sr_clear),
		.in_data(mac_rx_data),
		.in_last(mac_rx_last),
		.in_valid(mac_rx_valid && !dropping_r),
		.in_ready(mil_in_ready),
		.out_word(mil_word),
		.out_valid(mil_valid),
		.out_ready(rx_take)
	);

	always_ff @(posedge core_clk) begin
		if (rx_take) begin
			rx_mem[rx_wp_r[PW-2:0]] <= mil_word[31:0];
			rx_last_mem[rx_wp_r[PW-2:0]] <= mil_word[32];
		end
	end

	// overrun drops the rest of the frame and further frames until data fifo has room
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dropping_r <= 1'b0;
			in_frame_r <= 1'b0;
			drop_cnt_r <= '0;
		end else if (sr_clear) begin
			dropping_r <= 1'b0;
			in_frame_r <= 1'b0;
			drop_cnt_r <= '0;
		end else if (mac_rx_valid) begin
			in_frame_r <= !mac_rx_last;
			if (!in_frame_r && dropping_r && !rx_data_full_r) begin
				dropping_r <= 1'b0;
			end else if (!dropping_r && !mil_in_ready) begin
				dropping_r <= 1'b1;
				drop_cnt_r <= drop_cnt_r + 16'h0001;
			end else if (dropping_r && !in_frame_r) begin
				drop_cnt_r <= drop_cnt_r + 16'h0001;
			end
		end
	end

	assign rx_pop = (bus.rd && bus.addr == HFP_OFS_RX_DATA && rx_used != '0) ||
		(ffwd_r && rx_used != '0);

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_data_full_r <= 1'b0;
		end else if (sr_clear) begin
			rx_wp_r <= '0;
			rx_rp_r <= '0;
			rx_data_full_r <= 1'b0;
		end else begin
			rx_wp_r <= rx_wp_r + PW'(rx_take);
			rx_rp_r <= rx_rp_r + PW'(rx_pop);
			rx_data_full_r <= (rx_used + PW'(rx_take) >= rx_cap_dw);
		end
	end

	// skip: pop words until the frame's last word leaves
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ffwd_r <= 1'b0;
		end else if (sr_clear) begin
			ffwd_r <= 1'b0;
		end else if (ffwd_r) begin
			if (rx_used != '0 && rx_last_mem[rx_rp_r[PW-2:0]]) begin
				ffwd_r <= 1'b0;
			end
		end else if (wr_ok && bus.addr == HFP_OFS_RX_PATH && bus.wdata[HFP_FFWD_BIT]) begin
			ffwd_r <= 1'b1;
		end
	end

	// ==========================================================
	// transmit internal buffer occupancy (payload path not modelled here)
	logic [11:0] tx_mil_r;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_mil_r <= '0;
			mac_tx_avail <= 1'b0;
		end else if (sr_clear) begin
			tx_mil_r <= '0;
			mac_tx_avail <= 1'b0;
		end else begin
			if (tx_mil_r < 12'(HFP_MIL_TX_BYTES / 4) && !mac_tx_take) begin
				tx_mil_r <= tx_mil_r + 12'h001;
			end else if (mac_tx_take && tx_mil_r != '0) begin
				tx_mil_r <= tx_mil_r - 12'h001;
			end
			mac_tx_avail <= (tx_mil_r != '0);
		end
	end

	// ==========================================================
	// read data, one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.rdata <= '0;
		end else if (bus.rd) begin
			case (bus.addr)
				HFP_OFS_RX_DATA: bus.rdata <= rx_mem[rx_rp_r[PW-2:0]];
				HFP_OFS_HARDWARE_CONFIGURATION: bus.rdata <= {2'b00, kept_across_soft_reset_r, 3'b000, amdix_r,
					3'b000, mbo_r, transmit_alloc_size_r, 14'h0000,
					soft_reset_timeout_flag_r, soft_reset_request_r};
				HFP_OFS_RX_PATH: bus.rdata <= {ffwd_r, 31'h0000_0000};
				HFP_OFS_RX_INF: bus.rdata <= {16'h0000, 16'(rx_used) << 2};
				HFP_OFS_TX_INF: bus.rdata <= {16'h0000, tx_data_bytes};
				HFP_OFS_DROP: bus.rdata <= {16'h0000, drop_cnt_r};
				default: bus.rdata <= '0;
			endcase
		end else begin
			bus.rdata <= '0;
		end
	end
endmodule

// file: hfp_host.sv
// module: host end, turns user commands into bus cycles on the device port

module hfp_host import hfp_pkg::*; (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// device port
	hfp_if.host bus,
	// user command port
	input wire logic [7:0] cmd_addr,
	input wire logic [31:0] cmd_wdata,
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	output logic [31:0] cmd_rdata_r,
	output logic cmd_rvalid_r,
	output logic cmd_busy_r
);
	logic read_done_r;
	logic rd_pend_r;
	logic skip_wait_r;
	logic [31:0] hold_wdata_r;
	logic [7:0] hold_addr_r;
	logic hold_wr_r;

	// a dummy read is issued before the first write unless a read came first; reads of any register wait out a skip
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus.addr <= '0;
			bus.wdata <= '0;
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			read_done_r <= 1'b0;
			hold_wr_r <= 1'b0;
			hold_addr_r <= '0;
			hold_wdata_r <= '0;
			cmd_busy_r <= 1'b0;
			skip_wait_r <= 1'b0;
		end else begin
			bus.wr <= 1'b0;
			bus.rd <= 1'b0;
			if (hold_wr_r) begin
				bus.addr <= hold_addr_r;
				bus.wdata <= hold_wdata_r;
				bus.wr <= 1'b1;
				hold_wr_r <= 1'b0;
				cmd_busy_r <= 1'b0;
			end else if (cmd_wr && !cmd_busy_r) begin
				if (!read_done_r) begin
					bus.addr <= HFP_OFS_HARDWARE_CONFIGURATION;
					bus.rd <= 1'b1;
					read_done_r <= 1'b1;
					hold_wr_r <= 1'b1;
					hold_addr_r <= cmd_addr;
					hold_wdata_r <= cmd_wdata;
					cmd_busy_r <= 1'b1;
				end else begin
					bus.addr <= cmd_addr;
					bus.wdata <= cmd_wdata;
					bus.wr <= 1'b1;
					skip_wait_r <= (cmd_addr == HFP_OFS_RX_PATH) && cmd_wdata[HFP_FFWD_BIT];
				end
			end else if (cmd_rd && !cmd_busy_r && !skip_wait_r) begin
				bus.addr <= cmd_addr;
				bus.rd <= 1'b1;
				read_done_r <= 1'b1;
			end else if (skip_wait_r && !rd_pend_r) begin
				bus.addr <= HFP_OFS_RX_PATH;
				bus.rd <= 1'b1;
			end
			if (rd_pend_r && bus.addr == HFP_OFS_RX_PATH && !bus.rdata[HFP_FFWD_BIT]) begin
				skip_wait_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_pend_r <= 1'b0;
			cmd_rdata_r <= '0;
			cmd_rvalid_r <= 1'b0;
		end else begin
			rd_pend_r <= bus.rd;
			cmd_rvalid_r <= rd_pend_r;
			if (rd_pend_r) begin
				cmd_rdata_r <= bus.rdata;
			end
		end
	end
endmodule

// file: hfp_assertions.sv
// checker: relations on the host bus between the host end and the device end
module hfp_assertions import hfp_pkg::*; #(
	parameter int SOFT_RESET_TIMEOUT_FLAG_CYC = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// host bus
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [31:0] rdata
);
	// ====================
	// helper state
	logic seen_rd_r, sz_ok_r, cfg_wr;
	logic [3:0] sz_r;
	logic [9:0] soft_reset_request_cnt_r, skip_cnt_r;
	assign cfg_wr = wr && seen_rd_r && addr == HFP_OFS_HARDWARE_CONFIGURATION;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seen_rd_r <= 1'b0;
			sz_ok_r <= 1'b1;
			sz_r <= HFP_TXSZ_RESET;
		end else begin
			seen_rd_r <= seen_rd_r | rd;
			if (cfg_wr) begin
				sz_r <= wdata[HFP_TXSZ_LSB+:4];
				// size after a soft reset write is not modelled
				sz_ok_r <= !wdata[HFP_SOFT_RESET_REQUEST_BIT];
			end
		end
	end
	// saturating ages of the last soft reset and skip requests
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			soft_reset_request_cnt_r <= 10'h000;
			skip_cnt_r <= 10'h000;
		end else begin
			if (cfg_wr && wdata[HFP_SOFT_RESET_REQUEST_BIT]) soft_reset_request_cnt_r <= 10'h001;
			else if (soft_reset_request_cnt_r != 10'h000 && soft_reset_request_cnt_r != 10'h3ff) soft_reset_request_cnt_r <= soft_reset_request_cnt_r + 10'h001;
			if (wr && addr == HFP_OFS_RX_PATH && wdata[HFP_FFWD_BIT]) skip_cnt_r <= 10'h001;
			else if (skip_cnt_r != 10'h000 && skip_cnt_r != 10'h3ff) skip_cnt_r <= skip_cnt_r + 10'h001;
		end
	end
	// ====================
	// assertions
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	strobe_excl_a: assert property (!(wr && rd))
		else $error("read and write strobes together");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0000_0000)
		else $error("read data outside its cycle");
	read_first_a: assert property (wr |-> seen_rd_r)
		else $error("write before any read");
	size_rb_a: assert property (rd && addr == HFP_OFS_HARDWARE_CONFIGURATION && sz_ok_r |=> rdata[HFP_TXSZ_LSB+:4] == sz_r)
		else $error("size field readback wrong");
	tx_alloc_a: assert property (rd && addr == HFP_OFS_TX_INF && sz_ok_r |=> rdata == 32'(sz_r) * HFP_KB - HFP_TX_STAT_BYTES)
		else $error("transmit data size wrong");
	soft_reset_request_done_a: assert property (rd && addr == HFP_OFS_HARDWARE_CONFIGURATION && soft_reset_request_cnt_r > 10'(SOFT_RESET_TIMEOUT_FLAG_CYC + 8) |=> !rdata[HFP_SOFT_RESET_REQUEST_BIT])
		else $error("soft reset bit stuck");
	skip_done_a: assert property (rd && addr == HFP_OFS_RX_PATH && skip_cnt_r > 10'h028 |=> !rdata[HFP_FFWD_BIT])
		else $error("skip bit stuck");
	rx_level_a: assert property (rd && addr == HFP_OFS_RX_INF |=> rdata[1:0] == 2'b00)
		else $error("receive level not whole words");
	cover property (cfg_wr && wdata[HFP_SOFT_RESET_REQUEST_BIT]);
	cover property (wr && addr == HFP_OFS_RX_PATH && wdata[HFP_FFWD_BIT]);
	cover property (rd && addr == HFP_OFS_DROP);
endmodule

// file: hfp_tb.sv
// testbench: host end and device end joined, driven from the user command port and the mac side
module hfp_tb import hfp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TO = 20;
	// receive data words at the 14 KB transmit allocation that the size test leaves
	localparam int RXW = (HFP_TOTAL_BYTES - 14 * HFP_KB) * (HFP_RX_STAT_DIV - 1) / HFP_RX_STAT_DIV / 4;
	logic core_clk = 1'b0, rst_n = 1'b0, cmd_wr = 1'b0, cmd_rd = 1'b0;
	logic mac_rx_last = 1'b0, mac_rx_valid = 1'b0, mac_rx_err = 1'b0, mac_tx_err = 1'b0;
	logic mac_tx_take = 1'b0, phy_clks_running = 1'b1, amdix_strap = 1'b1;
	logic [7:0] cmd_addr = 8'h00;
	logic [31:0] cmd_wdata = 32'h0000_0000, mac_rx_data = 32'h0000_0000, rv, cmd_rdata_r;
	logic cmd_rvalid_r, cmd_busy_r, mac_tx_avail, tx_error_flag_r, rx_error_flag_r, rx_data_full_r;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	hfp_if bus();
	hfp_device #(.SOFT_RESET_TIMEOUT_FLAG_CYC(TO)) i_hfp_device (.core_clk, .rst_n, .bus(bus), .mac_rx_data,
		.mac_rx_last, .mac_rx_valid, .mac_rx_err, .mac_tx_err, .mac_tx_take, .mac_tx_avail,
		.phy_clks_running, .amdix_strap, .tx_error_flag_r, .rx_error_flag_r, .rx_data_full_r);
	hfp_host i_hfp_host (.core_clk, .rst_n, .bus(bus), .cmd_addr, .cmd_wdata, .cmd_wr, .cmd_rd,
		.cmd_rdata_r, .cmd_rvalid_r, .cmd_busy_r);
	hfp_assertions #(.SOFT_RESET_TIMEOUT_FLAG_CYC(TO)) i_hfp_assertions (.core_clk, .rst_n, .addr(bus.addr),
		.wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata));
	always #12.5 core_clk = ~core_clk;
	// ====================
	// tasks
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic idle();
		for (int n = 0; n < 500 && cmd_busy_r !== 1'b0; n++) @(posedge core_clk);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		idle();
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge core_clk);
		cmd_wr <= 1'b0;
		repeat (3) @(posedge core_clk);
		idle();
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		idle();
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge core_clk);
		cmd_rd <= 1'b0;
		for (int n = 0; n < 500 && cmd_rvalid_r !== 1'b1; n++) @(posedge core_clk);
		d = cmd_rdata_r;
	endtask
	// one frame, then time for the internal buffer to drain
	task automatic push(input int n, input logic [31:0] base);
		for (int i = 0; i < n; i++) begin
			mac_rx_valid <= 1'b1;
			mac_rx_data <= base + 32'(i);
			mac_rx_last <= (i == n - 1);
			@(posedge core_clk);
		end
		mac_rx_valid <= 1'b0;
		mac_rx_last <= 1'b0;
		repeat (60) @(posedge core_clk);
	endtask
	task automatic soft_reset_request(input logic [31:0] d);
		wr_reg(HFP_OFS_HARDWARE_CONFIGURATION, d);
		repeat (TO + 10) @(posedge core_clk);
		rd_reg(HFP_OFS_HARDWARE_CONFIGURATION, rv);
	endtask
	// ====================
	// tests
	initial begin
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		@(posedge core_clk);
		rd_reg(HFP_OFS_HARDWARE_CONFIGURATION, rv);
		chk("cfg", 32'h0105_0000, rv & 32'h311F_0003);
		rd_reg(HFP_OFS_TX_INF, rv);
		chk("tx_free", 32'h0000_1200, rv);
		chk("tx_avail", 32'h0000_0001, {31'h0, mac_tx_avail});
		$display("test reset done");
		phy_clks_running <= 1'b0;
		soft_reset_request(32'h0000_0001);
		chk("soft_reset_timeout_flag", 32'h0000_0002, rv & 32'h0000_0003);
		phy_clks_running <= 1'b1;
		$display("test timeout done");
		for (int s = 2; s <= 14; s++) begin
			wr_reg(HFP_OFS_HARDWARE_CONFIGURATION, (32'(s) << HFP_TXSZ_LSB) | 32'h0010_0000);
			rd_reg(HFP_OFS_TX_INF, rv);
			chk("tx_free", 32'(s * HFP_KB - HFP_TX_STAT_BYTES), rv);
		end
		$display("test sizes done");
		push(RXW - 5, 32'h0000_0000);
		chk("full", 32'h0000_0000, {31'h0, rx_data_full_r});
		rd_reg(HFP_OFS_RX_INF, rv);
		chk("rx_used", 32'((RXW - 5) * 4), {16'h0000, rv[15:0]});
		push(1, 32'h0000_0000);
		chk("full", 32'h0000_0001, {31'h0, rx_data_full_r});
		// the first frame outgrows the internal buffer, the second is dropped whole while the data fifo is full: one drop at overrun, one per new frame
		push(40, 32'h0000_0000);
		push(40, 32'h0000_0000);
		rd_reg(HFP_OFS_DROP, rv);
		chk("drops", 32'h0000_0002, rv);
		$display("test fill done");
		mac_rx_err <= 1'b1;
		mac_tx_err <= 1'b1;
		mac_tx_take <= 1'b1;
		@(posedge core_clk);
		mac_rx_err <= 1'b0;
		mac_tx_err <= 1'b0;
		mac_tx_take <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk("errs", 32'h0000_0003, {30'h0, tx_error_flag_r, rx_error_flag_r});
		soft_reset_request(32'h3007_0001);
		chk("cfg", 32'h3105_0000, rv & 32'h311F_0001);
		chk("errs", 32'h0000_0000, {30'h0, tx_error_flag_r, rx_error_flag_r});
		rd_reg(HFP_OFS_DROP, rv);
		chk("drops", 32'h0000_0000, rv);
		rd_reg(HFP_OFS_RX_INF, rv);
		chk("rx_used", 32'h0000_0000, rv);
		$display("test soft reset done");
		push(6, 32'hA000_0000);
		push(3, 32'hB000_0000);
		rd_reg(HFP_OFS_RX_DATA, rv);
		chk("rx_word", 32'hA000_0000, rv);
		wr_reg(HFP_OFS_RX_PATH, 32'h8000_0000);
		rv = 32'hFFFF_FFFF;
		for (int i = 0; i < 20 && rv[HFP_FFWD_BIT] !== 1'b0; i++) rd_reg(HFP_OFS_RX_PATH, rv);
		repeat (45) @(posedge core_clk);
		rd_reg(HFP_OFS_RX_PATH, rv);
		chk("skip_bit", 32'h0000_0000, rv);
		rd_reg(HFP_OFS_RX_DATA, rv);
		chk("rx_word", 32'hB000_0000, rv);
		rd_reg(HFP_OFS_RX_INF, rv);
		chk("rx_used", 32'h0000_0008, {16'h0000, rv[15:0]});
		$display("test skip done");
		results();
	end
endmodule
